/* core/wfp_cfg.svh */
// Register offsets, field positions, reset values and timing counts for the wire fault protect registers
`ifndef WFP_CFG_SVH
`define WFP_CFG_SVH
`define WFP_ADDR_W          6
`define WFP_OFF_WIRE_CFG1   6'h14
`define WFP_OFF_FLT_STAT2   6'h15
`define WFP_CFG_RESET       16'h0000
`define WFP_STAT_RESET      16'h0000
`define WFP_CFG_WMASK       16'hc7ff
`define WFP_CLK_HZ          100000000
// Cool-down times in milliseconds
`define WFP_COOL1_MS        800
`define WFP_COOL2_MS        2000
`define WFP_COOL3_MS        4000
// Delayed turn-off times in microseconds
`define WFP_DLY0_US         200
`define WFP_DLY1_US         400
`define WFP_DLY2_US         1000
`define WFP_DLY3_US         2000
`define WFP_TICK_US         1
`define WFP_TICK_CYC        ((`WFP_CLK_HZ / 1000000) * `WFP_TICK_US)
`define WFP_TICK_W          7
`define WFP_CNT_W           23
`define WFP_B_LATCH         11
`define WFP_B_ANY           10
`define WFP_B_SWST          9
`define WFP_B_HEAT          7
`define WFP_B_WAKE          6
`define WFP_B_OTSD          5
`define WFP_B_OC            4
`define WFP_B_SHORT         3
`define WFP_B_OLOFF         2
`define WFP_B_OLON          1
`define WFP_B_WARN          0
`endif

/* core/wfp_pkg.sv */
// Types shared by the wire fault protect register block
package wfp_pkg;
  typedef struct packed {
    logic [1:0] cooldown_select;
    logic [2:0] rsvd;
    logic [1:0] delayed_off_timer_select;
    logic [1:0] delayed_off_current_select;
    logic [3:0] heat_trip_select;
    logic [2:0] nominal_current_select;
  } wfp_cfg_t;

  typedef struct packed {
    logic overheat_shutdown;
    logic overcurrent_off;
    logic supply_short;
    logic off_open_load;
    logic on_open_load;
    logic overheat_warning;
    logic reverse_current;
    logic heat_overcurrent;
    logic wake_event;
    logic temp_below_reset;
  } wfp_cond_t;

  typedef enum logic [1:0] {
    WFP_IDLE,
    WFP_COOL,
    WFP_LATCHED
  } wfp_retry_t;
endpackage

/* core/wfp_sync.sv */
// Three-flop synchroniser with agreement of the last two stages
`timescale 1ns/1ps
module wfp_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         sys_rst,
  // Data
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
    end else begin
      s1 <= din;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // A change counts only once stages two and three agree
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          dout[i] <= 1'b0;
        end else if (s2[i] == s3[i]) begin
          dout[i] <= s3[i];
        end
      end
    end
  endgenerate
endmodule

/* core/wfp_timer.sv */
// Down counter with a load and a done pulse, clocked by a tick enable
`timescale 1ns/1ps
module wfp_timer #(
  parameter int W = 23
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         sys_rst,
  // Control
  input  wire logic         tick,
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  input  wire logic         stop,
  // Status
  output logic              running,
  output logic              done
);
  logic [W-1:0] cnt;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cnt     <= '0;
      running <= 1'b0;
      done    <= 1'b0;
    end else begin
      done <= 1'b0;
      if (stop) begin
        running <= 1'b0;
      end else if (load) begin
        cnt     <= load_val;
        running <= 1'b1;
      end else if (running && tick) begin
        if (cnt <= W'(1)) begin
          running <= 1'b0;
          done    <= 1'b1;
        end else begin
          cnt <= cnt - W'(1);
        end
      end
    end
  end
endmodule

/* core/wfp_regs.sv */
// Wire protection configuration and channel fault status registers
//
// Functional notes
// R1 - Cool-down code 0 latches off; codes 1-3 retry after 0.8, 2.0, 4.0 s.
// R2 - Delayed-off timer code picks 0.2, 0.4, 1.0 or 2.0 ms overcurrent allowance.
// R3 - Delayed-off current code picks threshold 19.55, 17.6, 16.05, 13.3 at 700 ohm.
// R4 - Four-bit trip code sets heat integral trip, 8.8 to 350 A2s.
// R5 - Three-bit code sets nominal current, 4.0 to 15.0 A.
// R6 - Latched-off flag high while latched off, clears when switched back on.
// R7 - Any-fault flag set while any real-time fault is present.
// R8 - Switch-state flag shows present on or off state.
// R9 - Heat fault sets only when enabled; clears on read once condition gone.
// R10 - Wake-cause flag set when this channel ended low-power mode.
// R11 - Overheat shutdown latches; clears on read when temperature below reset level.
// R12 - Overcurrent flag latches on turn-off; clears on read after condition ends.
// R13 - Supply-short flag latches if detection enabled; clears on read once gone.
// R14 - Off-state open-load flag valid only while its detection is enabled.
// R15 - On-state open-load flag valid only while its detection is enabled.
// R16 - Overheat warning follows the live temperature condition.
// R17 - Latch option keeps a faulted channel off until switch command rewritten.
// R18 - Capacitive charging delays heat integral accumulation until charging ends.
// R19 - Status read returns pre-read values; clearing takes effect after the read.
// R20 - Host reads fault status after a fault indication to learn and clear.
`timescale 1ns/1ps
`include "wfp_cfg.svh"
module wfp_regs (
  // Clock and reset
  input  wire logic                       clk,
  input  wire logic                       sys_rst,
  // Register port from the serial frame decoder
  input  wire logic                       reg_wr,
  input  wire logic                       reg_rd,
  input  wire logic [`WFP_ADDR_W-1:0]     reg_addr,
  input  wire logic [15:0]                reg_wdata,
  output logic      [15:0]                reg_rdata,
  output logic                            reg_rvalid,
  // Channel one wire protection settings to the protection core
  output wfp_pkg::wfp_cfg_t               wire_cfg,
  input  wire logic                       ch1_heat_trip,
  input  wire logic                       ch1_over_delay_thr,
  input  wire logic                       fault_latch_select,
  input  wire logic                       switch_command_wr,
  output logic                            ch1_shutdown,
  output logic                            ch1_retry,
  // Channel two live conditions from the analog front end
  input  wire wfp_pkg::wfp_cond_t         ch2_cond,
  input  wire logic                       ch2_on,
  input  wire logic                       ch2_latched,
  input  wire logic                       heat_protect_enable,
  input  wire logic                       cap_charge_active,
  input  wire logic                       supply_short_detect_enable,
  input  wire logic                       off_open_load_enable,
  input  wire logic                       on_open_load_enable,
  input  wire logic                       low_power_state,
  // Heat integral accumulate permit
  output logic                            heat_accumulate
);
  import wfp_pkg::*;

  // ==================================================================
  // Input synchronisation
  // ==================================================================
  // Analog conditions come from another domain and pass three flops and an agreement output flop
  localparam int CW = $bits(wfp_cond_t) + 2;
  logic [CW-1:0] raw_in;
  logic [CW-1:0] syn_in;
  wfp_cond_t     cond;
  logic          on_s;
  logic          latched_s;

  assign raw_in = {ch2_cond, ch2_on, ch2_latched};

  wfp_sync #(.W(CW)) u_sync (
    .clk     (clk),
    .sys_rst (sys_rst),
    .din     (raw_in),
    .dout    (syn_in)
  );

  assign cond      = wfp_cond_t'(syn_in[CW-1:2]);
  assign on_s      = syn_in[1];
  assign latched_s = syn_in[0];

  // ==================================================================
  // Address decode
  // ==================================================================
  function automatic logic hit(input logic [`WFP_ADDR_W-1:0] a, input logic [`WFP_ADDR_W-1:0] off);
    hit = (a == off);
  endfunction

  logic rd_stat;
  assign rd_stat = reg_rd && hit(reg_addr, `WFP_OFF_FLT_STAT2);

  // ==================================================================
  // Configuration register
  // ==================================================================
  // Reserved bits 13-11 are not writable and read as zero
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wire_cfg <= wfp_cfg_t'(`WFP_CFG_RESET);
    end else if (reg_wr && hit(reg_addr, `WFP_OFF_WIRE_CFG1)) begin
      wire_cfg <= wfp_cfg_t'(reg_wdata & `WFP_CFG_WMASK); // R1 R2 R3 R4 R5
    end
  end

  // ==================================================================
  // Channel one timing
  // ==================================================================
  logic [`WFP_TICK_W-1:0] pre;
  logic                   us_tick;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pre <= '0;
    end else if (pre == `WFP_TICK_W'(`WFP_TICK_CYC - 1)) begin
      pre <= '0;
    end else begin
      pre <= pre + `WFP_TICK_W'(1);
    end
  end
  assign us_tick = (pre == `WFP_TICK_W'(`WFP_TICK_CYC - 1));

  function automatic logic [`WFP_CNT_W-1:0] dly_us(input logic [1:0] code);
    case (code)
      2'h0:    dly_us = `WFP_CNT_W'(`WFP_DLY0_US);
      2'h1:    dly_us = `WFP_CNT_W'(`WFP_DLY1_US);
      2'h2:    dly_us = `WFP_CNT_W'(`WFP_DLY2_US);
      default: dly_us = `WFP_CNT_W'(`WFP_DLY3_US);
    endcase
  endfunction

  function automatic logic [`WFP_CNT_W-1:0] cool_us(input logic [1:0] code);
    case (code)
      2'h1:    cool_us = `WFP_CNT_W'(`WFP_COOL1_MS * 1000);
      2'h2:    cool_us = `WFP_CNT_W'(`WFP_COOL2_MS * 1000);
      default: cool_us = `WFP_CNT_W'(`WFP_COOL3_MS * 1000);
    endcase
  endfunction

  // Delayed turn-off: current above threshold for the selected time
  logic over_q;
  logic dly_done;
  logic dly_run;
  logic over_start;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      over_q <= 1'b0;
    end else begin
      over_q <= ch1_over_delay_thr;
    end
  end
  assign over_start = ch1_over_delay_thr && !over_q;

  wfp_timer #(.W(`WFP_CNT_W)) u_dly (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .tick     (us_tick),
    .load     (over_start),
    .load_val (dly_us(wire_cfg.delayed_off_timer_select)), // R2
    .stop     (!ch1_over_delay_thr),
    .running  (dly_run),
    .done     (dly_done)
  );

  // Retry sequencer after heat-integral or delayed-off shutdown
  wfp_retry_t state;
  logic       trip;
  logic       cool_done;
  logic       cool_load;
  assign trip      = (state == WFP_IDLE) && (ch1_heat_trip || dly_done);
  assign cool_load = trip && !fault_latch_select && (wire_cfg.cooldown_select != 2'h0); // R1 R17

  wfp_timer #(.W(`WFP_CNT_W)) u_cool (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .tick     (us_tick),
    .load     (cool_load),
    .load_val (cool_us(wire_cfg.cooldown_select)), // R1
    .stop     (1'b0),
    .running  (),
    .done     (cool_done)
  );

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state <= WFP_IDLE;
    end else begin
      case (state)
        WFP_IDLE: begin
          if (trip) begin
            state <= cool_load ? WFP_COOL : WFP_LATCHED; // R1 R17
          end
        end
        WFP_COOL: begin
          if (cool_done) begin
            state <= WFP_IDLE;
          end
        end
        WFP_LATCHED: begin
          if (switch_command_wr) begin
            state <= WFP_IDLE; // R17
          end
        end
        default: state <= WFP_IDLE;
      endcase
    end
  end

  assign ch1_shutdown = (state != WFP_IDLE);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ch1_retry <= 1'b0;
    end else begin
      ch1_retry <= (state == WFP_COOL) && cool_done;
    end
  end

  // Accumulation waits for the charging period to end
  assign heat_accumulate = heat_protect_enable && !cap_charge_active; // R18

  // ==================================================================
  // Channel two fault status
  // ==================================================================
  logic heat_f;
  logic wake_f;
  logic otsd_f;
  logic oc_f;
  logic short_f;
  logic lpm_q;

  // Set wins over a clear from the same read
  // A live condition with its enable off neither sets the bit nor lets it clear
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      heat_f <= 1'b0;
    end else if (heat_protect_enable && cond.heat_overcurrent) begin
      heat_f <= 1'b1; // R9
    end else if (rd_stat && !cond.heat_overcurrent) begin
      heat_f <= 1'b0; // R9 R19
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      otsd_f <= 1'b0;
    end else if (cond.overheat_shutdown) begin
      otsd_f <= 1'b1; // R11
    end else if (rd_stat && cond.temp_below_reset) begin
      otsd_f <= 1'b0; // R11 R19
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      oc_f <= 1'b0;
    end else if (cond.overcurrent_off) begin
      oc_f <= 1'b1; // R12
    end else if (rd_stat) begin
      oc_f <= 1'b0; // R12 R19
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      short_f <= 1'b0;
    end else if (supply_short_detect_enable && cond.supply_short) begin
      short_f <= 1'b1; // R13
    end else if (rd_stat && !cond.supply_short) begin
      short_f <= 1'b0; // R13 R19
    end
  end

  // Wake cause: a wake event seen while in low power; cleared when low power is re-entered
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      lpm_q  <= 1'b0;
      wake_f <= 1'b0;
    end else begin
      lpm_q <= low_power_state;
      if (lpm_q && cond.wake_event) begin
        wake_f <= 1'b1; // R10
      end else if (low_power_state && !lpm_q) begin
        wake_f <= 1'b0; // R10
      end
    end
  end

  logic [15:0] stat;
  always_comb begin
    stat                 = `WFP_STAT_RESET;
    stat[`WFP_B_LATCH]   = latched_s && !on_s; // R6
    stat[`WFP_B_ANY]     = cond.reverse_current || cond.overheat_shutdown || cond.supply_short
                         || (off_open_load_enable && cond.off_open_load)
                         || (on_open_load_enable && cond.on_open_load); // R7
    stat[`WFP_B_SWST]    = on_s; // R8
    stat[`WFP_B_HEAT]    = heat_f;
    stat[`WFP_B_WAKE]    = wake_f;
    stat[`WFP_B_OTSD]    = otsd_f;
    stat[`WFP_B_OC]      = oc_f;
    stat[`WFP_B_SHORT]   = short_f;
    stat[`WFP_B_OLOFF]   = off_open_load_enable && cond.off_open_load; // R14
    stat[`WFP_B_OLON]    = on_open_load_enable && cond.on_open_load; // R15
    stat[`WFP_B_WARN]    = cond.overheat_warning; // R16
  end

  // ==================================================================
  // Read port
  // ==================================================================
  // Read data captures the pre-clear values in the read cycle
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reg_rdata  <= 16'h0000;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        if (hit(reg_addr, `WFP_OFF_WIRE_CFG1)) begin
          reg_rdata <= 16'(wire_cfg);
        end else if (rd_stat) begin
          reg_rdata <= stat; // R19
        end else begin
          reg_rdata <= 16'h0000;
        end
      end
    end
  end

  // dly_run kept for observability of the delayed-off window
  logic unused_run;
  assign unused_run = dly_run;
endmodule

/* dv/wfp_regs_asserts.sv */
// Port-level property checker for the wire fault protect register block
`timescale 1ns/1ps
module wfp_regs_asserts import wfp_pkg::*; (
  // Clock and reset
  input wire logic               clk,
  input wire logic               sys_rst,
  // Register port
  input wire logic               reg_wr,
  input wire logic               reg_rd,
  input wire logic [5:0]         reg_addr,
  input wire logic [15:0]        reg_wdata,
  input wire logic [15:0]        reg_rdata,
  input wire logic               reg_rvalid,
  // Channel one
  input wire wfp_pkg::wfp_cfg_t  wire_cfg,
  input wire logic               fault_latch_select,
  input wire logic               switch_command_wr,
  input wire logic               ch1_shutdown,
  input wire logic               ch1_retry,
  // Channel two
  input wire wfp_pkg::wfp_cond_t ch2_cond,
  input wire logic               ch2_on,
  input wire logic               ch2_latched,
  input wire logic               heat_protect_enable,
  input wire logic               cap_charge_active,
  input wire logic               off_open_load_enable,
  input wire logic               on_open_load_enable,
  input wire logic               heat_accumulate
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // ==========================================================
  // Quiet counter: live bits are judged only once the synchroniser has settled
  logic [13:0] prev_in;
  logic [3:0]  quiet;
  logic        stat_rd;
  wire  [13:0] in_now = {ch2_cond, ch2_on, ch2_latched, off_open_load_enable, on_open_load_enable};
  assign stat_rd = reg_rd && reg_addr == 6'h15 && quiet >= 4'h8;
  always_ff @(posedge clk) begin
    prev_in <= in_now;
    if (sys_rst || in_now != prev_in) begin
      quiet <= 4'h0;
    end else if (quiet != 4'hf) begin
      quiet <= quiet + 4'h1;
    end
  end
  // ==========================================================
  // Properties
  a_rvalid_follows_rd: assert property (reg_rd |=> reg_rvalid)
    else $error("read answer missing");
  a_rvalid_has_cause: assert property ($rose(reg_rvalid) |-> $past(reg_rd))
    else $error("read answer without request");
  a_cfg_write_lands: assert property (reg_wr && reg_addr == 6'h14 |=> wire_cfg == ($past(reg_wdata) & 16'hc7ff))
    else $error("config write not applied");
  a_cfg_read_back: assert property (reg_rd && !reg_wr && reg_addr == 6'h14 |=> reg_rdata == $past(wire_cfg))
    else $error("config read back wrong");
  a_swstate_live: assert property (stat_rd |=> reg_rdata[9] == $past(ch2_on))
    else $error("switch state bit wrong");
  a_warn_live: assert property (stat_rd ##1 1'b1 |-> reg_rdata[0] == $past(ch2_cond.overheat_warning))
    else $error("warning bit wrong");
  a_olon_gated: assert property (stat_rd |=> reg_rdata[1] == $past(ch2_cond.on_open_load & on_open_load_enable))
    else $error("on open load bit wrong");
  a_oloff_gated: assert property (stat_rd |=> reg_rdata[2] == $past(ch2_cond.off_open_load & off_open_load_enable))
    else $error("off open load bit wrong");
  a_latched_bit: assert property (stat_rd |=> reg_rdata[11] == $past(ch2_latched & !ch2_on))
    else $error("latched off bit wrong");
  a_retry_one_cycle: assert property (ch1_retry |=> !ch1_retry)
    else $error("retry pulse too long");
  a_latch_holds: assert property (ch1_shutdown && !switch_command_wr && (fault_latch_select
    || wire_cfg.cooldown_select == 2'h0) |=> ch1_shutdown)
    else $error("latched channel released");
  a_accum_gate: assert property (heat_accumulate == (heat_protect_enable && !cap_charge_active))
    else $error("accumulate permit wrong");
  cover property (stat_rd);
  cover property ($rose(ch1_shutdown));
  cover property (ch1_shutdown && switch_command_wr);
endmodule
bind wfp_regs wfp_regs_asserts wfp_regs_asserts_i (.clk, .sys_rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
  .reg_rdata, .reg_rvalid, .wire_cfg, .fault_latch_select, .switch_command_wr, .ch1_shutdown, .ch1_retry,
  .ch2_cond, .ch2_on, .ch2_latched, .heat_protect_enable, .cap_charge_active, .off_open_load_enable,
  .on_open_load_enable, .heat_accumulate);

/* dv/wfp_host_model.sv */
// Host controller model issuing register reads and writes
`timescale 1ns/1ps
module wfp_host_model (
  // Clock
  input  wire logic        clk,
  // Requests
  output logic             reg_wr,
  output logic             reg_rd,
  output logic [5:0]       reg_addr,
  output logic [15:0]      reg_wdata,
  // Answers
  input  wire logic [15:0] reg_rdata,
  input  wire logic        reg_rvalid
);
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 6'h00;
    reg_wdata = 16'h0000;
  end
  // Idle address and data show the inverse so stale values never pass
  task automatic write(input logic [5:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask
  task automatic read(input logic [5:0] a, output logic [15:0] d);
    d = 16'hxxxx;
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    for (int n = 0; n < 4; n++) begin
      @(posedge clk);
      if (reg_rvalid === 1'b1) begin
        d = reg_rdata;
        break;
      end
    end
  endtask
endmodule

/* dv/wire_fault_protect_regs_tb_top.sv */
// Self-checking testbench for the wire fault protect register block
`timescale 1ns/1ps
module wire_fault_protect_regs_tb_top import wfp_pkg::*; ;
  logic clk, sys_rst, reg_wr, reg_rd, reg_rvalid, ch1_heat_trip, ch1_over_delay_thr, fault_latch_select;
  logic switch_command_wr, ch1_shutdown, ch2_on, ch2_latched, heat_protect_enable, cap_charge_active;
  logic supply_short_detect_enable, off_open_load_enable, on_open_load_enable, low_power_state;
  logic [5:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata, lat, got, d;
  wfp_cfg_t    wire_cfg;
  wfp_cond_t   cond;
  int          errors, checks;
  wfp_regs wfp_regs_i (.clk, .sys_rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .reg_rvalid,
    .wire_cfg, .ch1_heat_trip, .ch1_over_delay_thr, .fault_latch_select, .switch_command_wr, .ch1_shutdown,
    .ch1_retry(), .ch2_cond(cond), .ch2_on, .ch2_latched, .heat_protect_enable, .cap_charge_active,
    .supply_short_detect_enable, .off_open_load_enable, .on_open_load_enable, .low_power_state,
    .heat_accumulate());
  wfp_host_model wfp_host_model_i (.clk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .reg_rvalid);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ==========================================================
  // Checking and model
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] seen);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic test_done();
    if (errors == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Sticky bits: a live condition always wins over a clear
  task automatic apply();
    lat[7] = lat[7] | (cond.heat_overcurrent & heat_protect_enable);
    lat[5] = lat[5] | cond.overheat_shutdown;
    lat[4] = lat[4] | cond.overcurrent_off;
    lat[3] = lat[3] | (cond.supply_short & supply_short_detect_enable);
  endtask
  task automatic settle();
    repeat (8) @(posedge clk);
    apply();
  endtask
  task automatic rd_stat();
    logic [15:0] e, m;
    e = lat;
    e[11] = ch2_latched & ~ch2_on;
    e[10] = cond.reverse_current | cond.overheat_shutdown | cond.supply_short
      | (cond.off_open_load & off_open_load_enable) | (cond.on_open_load & on_open_load_enable);
    e[9] = ch2_on;
    e[2] = cond.off_open_load & off_open_load_enable;
    e[1] = cond.on_open_load & on_open_load_enable;
    e[0] = cond.overheat_warning;
    // An undetected short leaves the summary bit open
    m = (cond.supply_short && !supply_short_detect_enable) ? 16'hfbff : 16'hffff;
    wfp_host_model_i.read(6'h15, got);
    check("status", e & m, got & m);
    if (!cond.heat_overcurrent) lat[7] = 1'b0;
    if (cond.temp_below_reset) lat[5] = 1'b0;
    if (!cond.overcurrent_off) lat[4] = 1'b0;
    if (!cond.supply_short) lat[3] = 1'b0;
    apply();
  endtask
  task automatic trip(input logic [15:0] cfg, input logic sel, input int cyc);
    wfp_host_model_i.write(6'h14, cfg);
    fault_latch_select <= sel;
    ch1_over_delay_thr <= 1'b1;
    repeat (cyc - cyc / 20) @(posedge clk);
    check("early shutdown", 16'h0, {15'h0, ch1_shutdown});
    repeat (cyc / 10) @(posedge clk);
    check("shutdown", 16'h1, {15'h0, ch1_shutdown});
    ch1_over_delay_thr <= 1'b0;
    repeat (200) @(posedge clk);
    check("held off", 16'h1, {15'h0, ch1_shutdown});
    switch_command_wr <= 1'b1;
    @(posedge clk);
    switch_command_wr <= 1'b0;
    repeat (4) @(posedge clk);
    check("released", 16'h0, {15'h0, ch1_shutdown});
  endtask
  // ==========================================================
  // Watchdog and main sequence
  initial begin
    repeat (80000) @(posedge clk);
    errors++;
    test_done();
  end
  initial begin
    {ch1_heat_trip, ch1_over_delay_thr, fault_latch_select, switch_command_wr, ch2_on, ch2_latched} = 6'h00;
    {heat_protect_enable, cap_charge_active, supply_short_detect_enable} = 3'h0;
    {off_open_load_enable, on_open_load_enable, low_power_state} = 3'h0;
    cond = '0;
    lat = 16'h0000;
    sys_rst = 1'b1;
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    void'($urandom(88));
    wfp_host_model_i.read(6'h14, got);
    check("config reset", 16'h0000, got);
    rd_stat();
    for (int i = 0; i < 40; i++) begin
      d = 16'($urandom);
      wfp_host_model_i.write(6'h14, d);
      wfp_host_model_i.read(6'h14, got);
      check("config", d & 16'hc7ff, got);
      check("wire_cfg", d & 16'hc7ff, wire_cfg);
      {heat_protect_enable, cap_charge_active, supply_short_detect_enable} <= 3'($urandom);
      {off_open_load_enable, on_open_load_enable} <= 2'($urandom);
      settle();
      cond <= wfp_cond_t'(10'($urandom));
      {ch2_on, ch2_latched} <= 2'($urandom);
      settle();
      rd_stat();
      rd_stat();
    end
    wfp_host_model_i.write(6'h15, 16'hffff);
    rd_stat();
    wfp_host_model_i.read(6'h3f, got);
    check("unmapped", 16'h0000, got);
    low_power_state <= 1'b1;
    lat[6] = 1'b0;
    settle();
    cond.wake_event <= 1'b1;
    settle();
    low_power_state <= 1'b0;
    lat[6] = 1'b1;
    settle();
    rd_stat();
    trip(16'h0000, 1'b0, 20000);
    ch1_heat_trip <= 1'b1;
    repeat (4) @(posedge clk);
    ch1_heat_trip <= 1'b0;
    repeat (4) @(posedge clk);
    check("heat shutdown", 16'h1, {15'h0, ch1_shutdown});
    switch_command_wr <= 1'b1;
    @(posedge clk);
    switch_command_wr <= 1'b0;
    repeat (4) @(posedge clk);
    check("heat released", 16'h0, {15'h0, ch1_shutdown});
    trip(16'hc200, 1'b1, 40000);
    test_done();
  end
endmodule
